// ==== adfd_top.sv ====
// Adaptive frame-rate pixel dither unit: pre-table dither, white balance, post-table dither
`timescale 1ns/1ps
module adfd_top (
    input  wire logic                         clk_in,
    input  wire logic                         rst_b_in,
    input  wire logic [adfd_pkg::PIX_W-1:0]   rgb_in,
    input  wire logic                         line_sync_in,
    input  wire logic                         frame_sync_in,
    input  wire logic                         pixel_valid_in,
    input  wire logic                         de_only_mode_in,
    input  wire logic                         line_sync_low_in,
    input  wire logic                         frame_sync_low_in,
    input  wire logic                         pixel_valid_low_in,
    input  wire logic                         pre_lut_dither_en_in,
    input  wire logic                         post_lut_dither_en_in,
    input  wire logic                         white_balance_en_in,
    input  wire logic                         lut_wr_en_in,
    input  wire logic [1:0]                   lut_sel_in,
    input  wire logic [7:0]                   lut_addr_in,
    input  wire logic [7:0]                   lut_data_in,
    output logic      [adfd_pkg::PIX_W-1:0]   rgb_out,
    output logic                              line_sync_out,
    output logic                              frame_sync_out,
    output logic                              pixel_valid_out
);

    // ======================================================================
    // Dither arithmetic
    function automatic logic [4:0] adfd_rank(input logic [6:0] pos, input logic [1:0] col, input logic still);
        logic [4:0] base;
        base = {pos[0], pos[3], pos[1], pos[4], pos[2]};
        // Interleaving pixel and line bits spreads bumps across the group
        adfd_rank = base ^ {(still ? 2'h0 : pos[6:5]), 1'b0, col};
    endfunction

    function automatic logic [7:0] adfd_dith(input logic [7:0] c, input logic bw, input logic [6:0] pos,
                                             input logic [1:0] col);
        logic [8:0]               v9;
        logic [5:0]               up;
        logic                     bump;
        adfd_pkg::adfd_algo_t     alg;
        v9   = {c, c[7]};
        up   = v9[8:3];
        bump = 1'b0;
        if (bw) begin
            alg = adfd_pkg::ALG_BW_PIXEL;
        end else if (c == 8'h00 || c == 8'hFF) begin
            alg = adfd_pkg::ALG_FULL_SUB;
        end else if (up == 6'h00 || up == 6'h3F) begin
            alg = adfd_pkg::ALG_EDGE;
        end else begin
            alg = adfd_pkg::ALG_DEFAULT;
        end
        case (alg)
            adfd_pkg::ALG_DEFAULT: begin
                bump = adfd_rank(pos, col, 1'b0) < {v9[2:0], 2'b00};
            end
            adfd_pkg::ALG_EDGE: begin
                // Frame-fixed pattern near the rails avoids visible flicker
                bump = (up != 6'h3F) && (adfd_rank(pos, col, 1'b1) < {v9[2:0], 2'b00});
            end
            default: begin
                bump = 1'b0;
            end
        endcase
        adfd_dith = {6'(up + {5'h00, bump}), 2'b00};
    endfunction

    function automatic logic [23:0] adfd_pix(input logic [23:0] p, input logic [6:0] pos);
        logic bw;
        bw = (p == 24'h000000) || (p == 24'hFFFFFF);
        adfd_pix = {adfd_dith(p[23:16], bw, pos, 2'h0),
                    adfd_dith(p[15:8], bw, pos, 2'h1),
                    adfd_dith(p[7:0], bw, pos, 2'h2)};
    endfunction

    // ======================================================================
    // Timing decode and dither counters
    logic                             ls_act;
    logic                             fs_act;
    logic                             pv_act;
    logic                             ls_q_r;
    logic                             fs_q_r;
    logic                             pv_q_r;
    logic                             line_start;
    logic                             frame_start;
    logic [adfd_pkg::GAP_CNT_W-1:0]   gap_cnt_r;
    logic [adfd_pkg::PIX_IDX_W-1:0]   pix_r;
    logic [adfd_pkg::PIX_IDX_W-1:0]   pix_nxt;
    logic [adfd_pkg::LINE_IDX_W-1:0]  line_r;
    logic [adfd_pkg::LINE_IDX_W-1:0]  line_nxt;
    logic [adfd_pkg::FRAME_IDX_W-1:0] frame_r;
    logic [adfd_pkg::FRAME_IDX_W-1:0] frame_nxt;
    logic                             first_r;
    logic [adfd_pkg::POS_W-1:0]       pos_cur;

    assign ls_act = line_sync_in ^ line_sync_low_in;
    assign fs_act = frame_sync_in ^ frame_sync_low_in;
    assign pv_act = pixel_valid_in ^ pixel_valid_low_in;

    always_comb begin
        if (de_only_mode_in) begin
            line_start  = pv_act && !pv_q_r;
            frame_start = pv_act && !pv_q_r && (gap_cnt_r >= adfd_pkg::GAP_CNT_MAX);
        end else begin
            line_start  = ls_act && !ls_q_r;
            frame_start = fs_act && !fs_q_r;
        end
    end

    always_comb begin
        frame_nxt = frame_start ? frame_r + 2'h1 : frame_r;
        line_nxt  = line_r;
        if (line_start) begin
            line_nxt = (frame_start || first_r) ? 2'h0 : line_r + 2'h1;
        end
        pix_nxt = line_start ? 3'h0 : pix_r;
    end

    assign pos_cur = {frame_nxt, line_nxt, pix_nxt};

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ls_q_r <= 1'b0;
            fs_q_r <= 1'b0;
            pv_q_r <= 1'b0;
        end else begin
            ls_q_r <= ls_act;
            fs_q_r <= fs_act;
            pv_q_r <= pv_act;
        end
    end

    // Saturating blank counter; only meaningful in valid-only mode
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gap_cnt_r <= '0;
        end else if (pv_act) begin
            gap_cnt_r <= '0;
        end else if (gap_cnt_r != adfd_pkg::GAP_CNT_MAX) begin
            gap_cnt_r <= gap_cnt_r + 12'h001;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pix_r   <= 3'h0;
            line_r  <= 2'h0;
            frame_r <= 2'h0;
            first_r <= 1'b1;
        end else begin
            pix_r   <= pv_act ? pix_nxt + 3'h1 : pix_nxt;
            line_r  <= line_nxt;
            frame_r <= frame_nxt;
            if (line_start) begin
                first_r <= 1'b0;
            end else if (frame_start) begin
                first_r <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Stage 1: dither ahead of the white-balance table
    logic [adfd_pkg::PIX_W-1:0] s1_rgb_r;
    logic [adfd_pkg::POS_W-1:0] s1_pos_r;
    logic [2:0]                 s1_tim_r;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s1_rgb_r <= adfd_pkg::PIX_RST;
            s1_pos_r <= adfd_pkg::POS_RST;
            s1_tim_r <= 3'h0;
        end else begin
            s1_rgb_r <= pre_lut_dither_en_in ? adfd_pix(rgb_in, pos_cur) : rgb_in;
            s1_pos_r <= pos_cur;
            s1_tim_r <= {line_sync_in, frame_sync_in, pixel_valid_in};
        end
    end

    // ======================================================================
    // Stage 2: white-balance tables, one per colour
    logic [7:0]                 lut_mem [3][adfd_pkg::LUT_DEPTH];
    logic [adfd_pkg::PIX_W-1:0] s2_rgb_r;
    logic [adfd_pkg::POS_W-1:0] s2_pos_r;
    logic [2:0]                 s2_tim_r;

    // Table contents are software's; no reset, writes take effect at once
    always_ff @(posedge clk_in) begin
        if (lut_wr_en_in && lut_sel_in != 2'h3) begin
            lut_mem[lut_sel_in][lut_addr_in] <= lut_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s2_rgb_r <= adfd_pkg::PIX_RST;
            s2_pos_r <= adfd_pkg::POS_RST;
            s2_tim_r <= 3'h0;
        end else begin
            if (white_balance_en_in) begin
                s2_rgb_r <= {lut_mem[adfd_pkg::LUT_SEL_RED][s1_rgb_r[adfd_pkg::RED_LSB +: 8]],
                             lut_mem[adfd_pkg::LUT_SEL_GREEN][s1_rgb_r[adfd_pkg::GREEN_LSB +: 8]],
                             lut_mem[adfd_pkg::LUT_SEL_BLUE][s1_rgb_r[adfd_pkg::BLUE_LSB +: 8]]};
            end else begin
                s2_rgb_r <= s1_rgb_r;
            end
            s2_pos_r <= s1_pos_r;
            s2_tim_r <= s1_tim_r;
        end
    end

    // ======================================================================
    // Stage 3: dither after the table, driving the panel
    // A 6-bit source with 8-bit table values relies on this stage being on
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rgb_out         <= adfd_pkg::PIX_RST;
            line_sync_out   <= 1'b0;
            frame_sync_out  <= 1'b0;
            pixel_valid_out <= 1'b0;
        end else begin
            rgb_out         <= post_lut_dither_en_in ? adfd_pix(s2_rgb_r, s2_pos_r) : s2_rgb_r;
            line_sync_out   <= s2_tim_r[2];
            frame_sync_out  <= s2_tim_r[1];
            pixel_valid_out <= s2_tim_r[0];
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // Rank rebuilt from the position bits, kept apart from the datapath function
    logic [4:0] red_rank_w;
    assign red_rank_w = {pos_cur[0], pos_cur[3], pos_cur[1], pos_cur[4], pos_cur[2]} ^ {pos_cur[6:5], 3'h0};

    sequence s_frame_only;
        frame_start && !line_start;
    endsequence
    sequence s_quiet;
        !frame_start && !line_start;
    endsequence
    sequence s_first_line;
        line_start && !frame_start;
    endsequence

    white_pixel_exact_a: assert property (
        pre_lut_dither_en_in && rgb_in == 24'hFFFFFF |=> s1_rgb_r == 24'hFCFCFC)
        else $error("white pixel not passed exactly");

    bump_by_one_a: assert property (
        pre_lut_dither_en_in |=> (s1_rgb_r[23:18] - $past(rgb_in[23:18])) <= 6'h01)
        else $error("pre dither moved red by more than one");

    low_bits_zero_a: assert property (
        post_lut_dither_en_in |=> rgb_out[1:0] == 2'h0 && rgb_out[9:8] == 2'h0 && rgb_out[17:16] == 2'h0)
        else $error("low colour bits active while dithering");

    bypass_path_a: assert property (
        !pre_lut_dither_en_in ##1 !white_balance_en_in ##1 !post_lut_dither_en_in
        |=> rgb_out == $past(rgb_in, 3))
        else $error("undithered path does not pass pixel in three cycles");

    pix_restart_a: assert property (
        line_start |=> pix_r == {2'h0, $past(pv_act)})
        else $error("pixel index not restarted at line start");

    frame_step_a: assert property (
        frame_start |=> frame_r == $past(frame_r) + 2'h1)
        else $error("frame index did not advance");

    first_line_zero_a: assert property (
        s_frame_only ##1 s_quiet ##1 s_first_line |=> line_r == 2'h0)
        else $error("first line of frame not indexed zero");

    default_rate_a: assert property (
        pre_lut_dither_en_in && rgb_in == 24'h804040
        |=> s1_rgb_r[23:18] == (($past(red_rank_w) < 5'h04) ? 6'h21 : 6'h20))
        else $error("default pattern for 001 wrong");

    full_sub_exact_a: assert property (
        pre_lut_dither_en_in && rgb_in == 24'h00FF40 |=> s1_rgb_r[23:8] == 16'h00FC)
        else $error("full on or off sub-pixel was dithered");

    sync_delay_a: assert property (
        {line_sync_out, frame_sync_out, pixel_valid_out}
        == $past({line_sync_in, frame_sync_in, pixel_valid_in}, 3))
        else $error("timing outputs not delayed three cycles");

    pix_step_a: assert property (
        !line_start && pv_act |=> pix_r == $past(pix_r) + 3'h1)
        else $error("pixel index did not step on valid");

    table_bypass_a: assert property (
        !white_balance_en_in |=> s2_rgb_r == $past(s1_rgb_r))
        else $error("table stage altered pixel while bypassed");

    pre_off_pass_a: assert property (
        !pre_lut_dither_en_in |=> s1_rgb_r == $past(rgb_in))
        else $error("first stage altered pixel while disabled");

endmodule

// ==== adfd_pkg.sv ====
// Constants and types for the adaptive frame-rate pixel dither unit
// ==========================================================================
// Operation
// - With dithering on, each 24-bit pixel becomes an 18-bit pixel.
// - Temporal dithering varies the increment of a pixel from frame to frame.
// - Spatial dithering sets how many pixels in a small group get the increment.
// - Enhanced mode reaches all 16,777,216 source colours on an 18-bit panel; no such mode here, colour values FC to FF all give FC.
// - While dithering, the two low bits of each colour stay zero.
// - Two dither instances, each with its own independent enable.
// - First instance sits ahead of the white-balance table.
// - Second instance sits after the white-balance table, reducing its output.
// - Software sets timing mode and polarities; counters use them.
// - Each 8-bit colour is expanded to 9 bits before dithering.
// - The 9-bit value picks one of four algorithms; default serves most.
// - Black/white pixels and full on/off sub-pixels use special algorithms.
// - A pattern bit of one adds one to the 6-bit value.
// - Default pattern: truncated bits 001 bump 4 of 32 positions.
// - Each colour table holds 256 entries of 8 bits.
package adfd_pkg;
    localparam int COMP_W      = 8;
    localparam int DEPTH_W     = 6;
    localparam int PIX_W       = 24;
    localparam int LUT_DEPTH   = 256;
    localparam int PIX_IDX_W   = 3;
    localparam int LINE_IDX_W  = 2;
    localparam int FRAME_IDX_W = 2;
    localparam int POS_W       = 7;
    localparam int RANK_W      = 5;
    // Field positions of a packed pixel
    localparam int RED_LSB     = 16;
    localparam int GREEN_LSB   = 8;
    localparam int BLUE_LSB    = 0;
    // Table selectors
    localparam logic [1:0] LUT_SEL_RED   = 2'h0;
    localparam logic [1:0] LUT_SEL_GREEN = 2'h1;
    localparam logic [1:0] LUT_SEL_BLUE  = 2'h2;
    // Reset values
    localparam logic [PIX_W-1:0]  PIX_RST   = 24'h000000;
    localparam logic [POS_W-1:0]  POS_RST   = 7'h00;
    // Blanking needed before a frame start is inferred in valid-only mode
    localparam int CLK_PERIOD_NS = 10;
    localparam int DE_GAP_NS     = 20000;
    localparam int DE_GAP_CYC    = (DE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CNT_W     = 12;
    localparam logic [GAP_CNT_W-1:0] GAP_CNT_MAX = GAP_CNT_W'(DE_GAP_CYC);

    typedef enum logic [1:0] {
        ALG_DEFAULT,
        ALG_BW_PIXEL,
        ALG_FULL_SUB,
        ALG_EDGE
    } adfd_algo_t;
endpackage

// ==== adfd_panel_model.sv ====
// Display panel model: latches each pixel that arrives with active valid
`timescale 1ns/1ps
module adfd_panel_model (
    input  wire logic                       clk_in,
    input  wire logic [adfd_pkg::PIX_W-1:0] rgb_in,
    input  wire logic                       pixel_valid_in,
    input  wire logic                       pixel_valid_low_in,
    output logic                            pix_strobe_out,
    output logic      [adfd_pkg::PIX_W-1:0] pix_data_out
);
    // =====================================================================
    // Capture
    // Panel knows the programmed polarity, timing outputs are raw
    always_ff @(posedge clk_in) begin
        pix_strobe_out <= pixel_valid_in ^ pixel_valid_low_in;
        pix_data_out   <= rgb_in;
    end
endmodule

// ==== adfd_top_tb_top.sv ====
// Testbench for the adaptive dither unit with scoreboard queue
`timescale 1ns/1ps
module adfd_top_tb_top;
    logic        clk_in, rst_b_in, ls, fs, pv, mode, pol, pre, post, wb, we, quiet;
    logic [23:0] rgb;
    logic [1:0]  sel;
    logic [7:0]  addr, wdata;
    wire  [23:0] rgb_o, pdata;
    wire         pv_o, strobe;
    logic [47:0] notes[$];
    logic [47:0] n;
    logic [7:0]  s, b, nb;
    logic [31:0] mask[4];
    int          fails, checks_done, seed, seen_n, cnt[4][3];

    adfd_top uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .rgb_in(rgb), .line_sync_in(ls),
        .frame_sync_in(fs), .pixel_valid_in(pv), .de_only_mode_in(mode), .line_sync_low_in(pol),
        .frame_sync_low_in(pol), .pixel_valid_low_in(pol), .pre_lut_dither_en_in(pre),
        .post_lut_dither_en_in(post), .white_balance_en_in(wb), .lut_wr_en_in(we), .lut_sel_in(sel),
        .lut_addr_in(addr), .lut_data_in(wdata), .rgb_out(rgb_o), .line_sync_out(),
        .frame_sync_out(), .pixel_valid_out(pv_o));
    adfd_panel_model panel (.clk_in(clk_in), .rgb_in(rgb_o), .pixel_valid_in(pv_o),
        .pixel_valid_low_in(pol), .pix_strobe_out(strobe), .pix_data_out(pdata));

    // =====================================================================
    // Checking
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("Counts: %0d checks, %0d mismatches", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Note holds {no-bump value, bumped value}; equal halves mean exact
    always @(negedge clk_in) begin
        if (strobe === 1'b1 && !quiet) begin
            if (notes.size() == 0) begin
                check("unexpected pixel", 32'h1, 32'h0);
            end else begin
                n = notes.pop_front();
                for (int c = 0; c < 3; c++) begin
                    s  = pdata[c*8+:8];
                    b  = n[c*8+:8];
                    nb = n[24+c*8+:8];
                    if (s === b && b !== nb) begin
                        cnt[(seen_n/32)%4][c]++;
                        if (c == 2)
                            mask[(seen_n/32)%4][seen_n%32] = 1'b1;
                    end else begin
                        check("colour", {24'h0, s}, {24'h0, nb});
                    end
                end
                seen_n++;
            end
        end
    end

    // =====================================================================
    // Stimulus
    task automatic px(input logic [23:0] d, input logic v, l, f, input logic [47:0] note);
        @(negedge clk_in);
        rgb = d;
        pv  = v ^ pol;
        ls  = l ^ pol;
        fs  = f ^ pol;
        if (v)
            notes.push_back(note);
    endtask

    task automatic idle(input int k);
        repeat (k) px(24'h000000, 1'b0, 1'b0, 1'b0, 48'h0);
    endtask

    function automatic logic [47:0] dnote(input logic [23:0] d);
        logic [47:0] r;
        for (int c = 0; c < 3; c++) begin
            r[24+c*8+:8] = {d[c*8+2+:6], 2'b00};
            r[c*8+:8]    = {d[c*8+2+:6] + 6'h01, 2'b00};
        end
        return r;
    endfunction

    // Four frames of four lines of eight pixels, one colour value throughout
    task automatic frames(input logic [7:0] din, input logic [7:0] e0, input logic [7:0] e1);
        idle(6);
        seen_n = 0;
        cnt    = '{default: 0};
        mask   = '{default: 32'h0};
        for (int f = 0; f < 4; f++) begin
            for (int l = 0; l < 4; l++) begin
                if (mode && l == 0)
                    idle(2000);
                if (l == 0 && f % 2 == 1) begin
                    px(24'h000000, 1'b0, 1'b0, 1'b1, 48'h0);
                    px(24'h000000, 1'b0, 1'b0, 1'b0, 48'h0);
                end
                px(24'h000000, 1'b0, 1'b1, l == 0 && f % 2 == 0, 48'h0);
                repeat (8) px({3{din}}, 1'b1, 1'b0, 1'b0, {{3{e0}}, {3{e1}}});
            end
        end
        idle(8);
        for (int f = 0; f < 4; f++)
            for (int c = 0; c < 3; c++)
                check("bumps per frame", cnt[f][c], 4);
        check("frame pattern moves", {31'h0, mask[0] != mask[1]}, 32'h1);
        $display("Dither run on %0h done", din);
    endtask

    task automatic setpol(input logic p);
        quiet = 1'b1;
        pol   = p;
        idle(6);
        quiet = 1'b0;
    endtask

    task automatic randpix(input logic dith, input logic inv);
        logic [23:0] d;
        repeat (40) begin
            d = 24'($random(seed));
            px(d, 1'b1, 1'b0, 1'b0, dith ? dnote(d) : (inv ? {~d, ~d} : {d, d}));
        end
        idle(6);
        $display("Random run done");
    endtask

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    initial begin
        repeat (50000) @(posedge clk_in);
        check("run length", 32'h1, 32'h0);
        end_sim();
    end

    initial begin
        {rst_b_in, ls, fs, pv, mode, pol, pre, post, wb, we, quiet} = '0;
        {rgb, sel, addr, wdata} = '0;
        fails = 0;
        checks_done = 0;
        seed = 8;
        repeat (4) @(negedge clk_in);
        rst_b_in = 1'b1;
        randpix(1'b0, 1'b0);
        post = 1'b1;
        randpix(1'b1, 1'b0);
        px(24'hFFFFFF, 1'b1, 1'b0, 1'b0, {2{24'hFCFCFC}});
        px(24'h000000, 1'b1, 1'b0, 1'b0, {2{24'h000000}});
        px(24'h00FF00, 1'b1, 1'b0, 1'b0, {2{24'h00FC00}});
        idle(4);
        pre  = 1'b1;
        post = 1'b0;
        px(24'hFFFFFF, 1'b1, 1'b0, 1'b0, {2{24'hFCFCFC}});
        px(24'h00FF40, 1'b1, 1'b0, 1'b0, {2{24'h00FC40}});
        px(24'h804040, 1'b1, 1'b0, 1'b0, {24'h804040, 24'h844040});
        idle(4);
        pre  = 1'b0;
        post = 1'b1;
        frames(8'h80, 8'h80, 8'h84);
        setpol(1'b1);
        frames(8'h80, 8'h80, 8'h84);
        setpol(1'b0);
        mode = 1'b1;
        frames(8'h80, 8'h80, 8'h84);
        mode = 1'b0;
        post = 1'b0;
        // Tables in order red, green, blue, then ignored selector 3
        for (int t = 0; t < 4; t++)
            for (int a = 0; a < 256; a++) begin
                @(negedge clk_in);
                we    = 1'b1;
                sel   = t[1:0];
                addr  = a[7:0];
                wdata = (t == 3) ? 8'h55 : ~a[7:0];
            end
        @(negedge clk_in);
        we = 1'b0;
        wb = 1'b1;
        randpix(1'b0, 1'b1);
        pre = 1'b1;
        frames(8'h80, 8'h7F, 8'h7B);
        pre  = 1'b0;
        post = 1'b1;
        frames(8'h7F, 8'h80, 8'h84);
        check("notes left", notes.size(), 0);
        end_sim();
    end
endmodule
